//--- inc/ssp_pkg.sv
/*
  Types shared by the synchronous serial master port.
  Assumes nothing beyond the register header.
*/
package ssp_pkg;
  // Transfer sequencer states
  typedef enum logic [2:0] {
    SSP_IDLE,
    SSP_LOW,
    SSP_HIGH,
    SSP_HOLD
  } ssp_state_t;

  typedef logic [1:0] ssp_resp_t;
endpackage

//--- inc/ssp_regs.svh
/*
  Register map, field positions, reset values and encodings of the
  synchronous serial master port.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// Register indices; each register is one word at four times its index
`define SSP_IDX_STATUS    6'h10
`define SSP_IDX_CONTROL   6'h12
`define SSP_IDX_TX1       6'h14
`define SSP_IDX_TX0       6'h16
`define SSP_IDX_RECEIVE   6'h18

// Byte addresses of the registers
`define SSP_ADDR_STATUS   {`SSP_IDX_STATUS, 2'h0}
`define SSP_ADDR_CONTROL  {`SSP_IDX_CONTROL, 2'h0}
`define SSP_ADDR_TX1      {`SSP_IDX_TX1, 2'h0}
`define SSP_ADDR_TX0      {`SSP_IDX_TX0, 2'h0}
`define SSP_ADDR_RECEIVE  {`SSP_IDX_RECEIVE, 2'h0}

// Status fields
`define SSP_ST_BUSY       0
`define SSP_ST_DONE       1
`define SSP_ST_COLL       2

// Control fields
`define SSP_CT_EN0        0
`define SSP_CT_EN1        1
`define SSP_CT_DIV_LO     4
`define SSP_CT_DIV_HI     5
`define SSP_CTRL_RESET    16'h0000

// Clock-divide encodings
`define SSP_DIV_2         2'h0
`define SSP_DIV_4         2'h1
`define SSP_DIV_8         2'h2
`define SSP_DIV_16        2'h3

// Half-period counts in processor clocks, minus one
`define SSP_HALF_2        3'h0
`define SSP_HALF_4        3'h1
`define SSP_HALF_8        3'h3
`define SSP_HALF_16       3'h7

// Bits in a byte, index of the last bit
`define SSP_LAST_BIT      3'h7

// Bus responses
`define SSP_RESP_OKAY     2'h0
`define SSP_RESP_SLVERR   2'h2

`endif

//--- rtl/ssp_master.sv
/*
  Half-duplex synchronous serial master with AXI4-Lite register slave.
  Assumes one clock aclk, synchronous active-low reset, and an outside
  wire model that resolves the data pin from data_oe and keeps the last
  driven level when nobody drives.
*/
// What this block does
// - Shift clock is processor clock divided.
// - Divide field 00..11 picks 2,4,8,16.
// - Shift clock toggles in transfers, idles High.
// - Drive on falling edge, sample rising.
// - Bytes move least significant bit first.
// - Hold last written bit half period.
// - Keeper holds data line when undriven.
// - One shared data line, one direction.
// - Enable-select bits drive enable outputs.
// - Bit 1 and bit 0 select enables.
// - Both set asserts only enable 0.
// - Transmit write starts byte; busy ignored.
// - Receive read starts transfer if enabled.
// - Status bit 0 shows port busy.
// - Status bit 2 flags busy accesses.
// - Collision flag clears with enables off.
// - Status bit 1 set after bit 7.
// - Done clears on status read, transmit write, receive read or enables off.
// - Done set beats status-read clear.
// - Status read-only, resets zero, upper zero.
`timescale 1ns/100ps
`include "ssp_regs.svh"

module ssp_master (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output ssp_pkg::ssp_resp_t     s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output ssp_pkg::ssp_resp_t     s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   shift_clock,
  input  wire logic              shared_data_line_in,
  output logic                   shared_data_line_out,
  output logic                   shared_data_line_oe,
  output logic                   peripheral_enable_0,
  output logic                   peripheral_enable_1
);
  import ssp_pkg::*;

  ssp_state_t  state_r;
  logic [15:0] ctrl_r;
  logic [7:0]  tx1_r;
  logic [7:0]  tx0_r;
  logic [7:0]  rx_r;
  logic [7:0]  shift_r;
  logic [2:0]  bit_r;
  logic [2:0]  half_cnt_r;
  logic        writing_r;
  logic        busy_r;
  logic        done_r;
  logic        coll_r;
  logic        din_meta_r;
  logic        din_sync_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Half-period length from the divide field
  function automatic logic [2:0] half_len(input logic [1:0] div);
    unique case (div)
      `SSP_DIV_2:  half_len = `SSP_HALF_2;
      `SSP_DIV_4:  half_len = `SSP_HALF_4;
      `SSP_DIV_8:  half_len = `SSP_HALF_8;
      `SSP_DIV_16: half_len = `SSP_HALF_16;
    endcase
  endfunction

  // True for a mapped register address
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `SSP_ADDR_STATUS)  || (a == `SSP_ADDR_CONTROL) ||
                (a == `SSP_ADDR_TX1)     || (a == `SSP_ADDR_TX0)     ||
                (a == `SSP_ADDR_RECEIVE);
  endfunction

  logic [2:0] half_len_w;
  logic       any_en_w;
  logic       half_end_w;
  logic       wr_fire_w;
  logic       rd_fire_w;
  logic       tx_wr_w;
  logic       rx_rd_w;
  logic       st_rd_w;
  logic       start_tx_w;
  logic       start_rx_w;
  logic       finish_w;
  logic       last_end_w;
  logic [7:0] wr_addr_w;
  logic [31:0] wr_data_w;
  logic [3:0]  wr_strb_w;

  // Decode of control and bus strobes
  assign half_len_w = half_len(ctrl_r[`SSP_CT_DIV_HI:`SSP_CT_DIV_LO]);
  assign any_en_w   = ctrl_r[`SSP_CT_EN0] | ctrl_r[`SSP_CT_EN1];
  assign half_end_w = (half_cnt_r == half_len_w);
  assign wr_addr_w  = awaddr_r;
  assign wr_data_w  = wdata_r;
  assign wr_strb_w  = wstrb_r;
  // A write acts once, after both channels are captured
  assign wr_fire_w  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign rd_fire_w  = s_axi_arvalid & s_axi_arready;
  assign tx_wr_w    = wr_fire_w & wr_strb_w[0] &
                      ((wr_addr_w == `SSP_ADDR_TX1) ||
                       (wr_addr_w == `SSP_ADDR_TX0));
  assign rx_rd_w    = rd_fire_w & (s_axi_araddr == `SSP_ADDR_RECEIVE);
  assign st_rd_w    = rd_fire_w & (s_axi_araddr == `SSP_ADDR_STATUS);
  assign start_tx_w = tx_wr_w & ~busy_r;
  assign start_rx_w = rx_rd_w & ~busy_r & any_en_w;
  // Done at the rise that completes the last bit; busy ends a half later
  assign finish_w   = (state_r == SSP_LOW) & half_end_w &
                      (bit_r == `SSP_LAST_BIT);
  assign last_end_w = half_end_w & ((state_r == SSP_HOLD) |
                      ((state_r == SSP_HIGH) &
                       (bit_r == `SSP_LAST_BIT)));

  // Write address and data capture, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      // Each channel is taken at its own valid and ready edge
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire_w) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire_w) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Ready strobes and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSP_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid & ~aw_held_r & ~s_axi_awready &
                       ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~w_held_r & ~s_axi_wready &
                       ~s_axi_bvalid;
      if (wr_fire_w) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_addr_w) ? `SSP_RESP_OKAY
                                             : `SSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle accept, data next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSP_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire_w) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `SSP_RESP_OKAY
                                                : `SSP_RESP_SLVERR;
        unique case (s_axi_araddr)
          `SSP_ADDR_STATUS:  s_axi_rdata <= {29'h0000_0000, coll_r,
                                             done_r, busy_r};
          `SSP_ADDR_CONTROL: s_axi_rdata <= {16'h0000, ctrl_r};
          `SSP_ADDR_TX1:     s_axi_rdata <= {24'h00_0000, tx1_r};
          `SSP_ADDR_TX0:     s_axi_rdata <= {24'h00_0000, tx0_r};
          `SSP_ADDR_RECEIVE: s_axi_rdata <= {24'h00_0000, rx_r};
          default:           s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control register, written by low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SSP_CTRL_RESET;
    end else if (wr_fire_w && wr_strb_w[0] &&
                 wr_addr_w == `SSP_ADDR_CONTROL) begin
      ctrl_r <= {10'h000, wr_data_w[`SSP_CT_DIV_HI:`SSP_CT_DIV_LO],
                 2'h0, wr_data_w[`SSP_CT_EN1:`SSP_CT_EN0]};
    end
  end

  // Transmit data registers hold last value written while not busy; busy writes are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx1_r <= 8'h00;
      tx0_r <= 8'h00;
    end else if (tx_wr_w && !busy_r) begin
      if (wr_addr_w == `SSP_ADDR_TX1) begin
        tx1_r <= wr_data_w[7:0];
      end else begin
        tx0_r <= wr_data_w[7:0];
      end
    end
  end

  // Two-flop synchroniser for the data pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_meta_r <= 1'b0;
      din_sync_r <= 1'b0;
    end else begin
      din_meta_r <= shared_data_line_in;
      din_sync_r <= din_meta_r;
    end
  end

  // Transfer sequencer: low half drives, high half samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= SSP_IDLE;
      half_cnt_r <= 3'h0;
      bit_r      <= 3'h0;
      shift_r    <= 8'h00;
      writing_r  <= 1'b0;
      rx_r       <= 8'h00;
    end else begin
      unique case (state_r)
        SSP_IDLE: begin
          half_cnt_r <= 3'h0;
          bit_r      <= 3'h0;
          if (start_tx_w) begin
            state_r   <= SSP_LOW;
            writing_r <= 1'b1;
            shift_r   <= wr_data_w[7:0];
          end else if (start_rx_w) begin
            state_r   <= SSP_LOW;
            writing_r <= 1'b0;
          end
        end
        SSP_LOW: begin
          half_cnt_r <= half_end_w ? 3'h0 : half_cnt_r + 3'h1;
          if (half_end_w) begin
            // Rising edge; a written last bit stays driven one half
            if (writing_r && bit_r == `SSP_LAST_BIT) begin
              state_r <= SSP_HOLD;
            end else begin
              state_r <= SSP_HIGH;
            end
          end
        end
        SSP_HIGH: begin
          half_cnt_r <= half_end_w ? 3'h0 : half_cnt_r + 3'h1;
          if (half_end_w) begin
            // End of high half: take incoming bit into top, shift right
            if (!writing_r) begin
              shift_r <= {din_sync_r, shift_r[7:1]};
            end else begin
              shift_r <= {1'b0, shift_r[7:1]};
            end
            bit_r <= bit_r + 3'h1;
            if (bit_r == `SSP_LAST_BIT) begin
              // Only a receive reaches here on its last bit
              state_r <= SSP_IDLE;
              rx_r    <= {din_sync_r, shift_r[7:1]};
            end else begin
              state_r <= SSP_LOW;
            end
          end
        end
        SSP_HOLD: begin
          half_cnt_r <= half_end_w ? 3'h0 : half_cnt_r + 3'h1;
          if (half_end_w) begin
            state_r   <= SSP_IDLE;
            writing_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Busy flag follows the sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else if (start_tx_w || start_rx_w) begin
      busy_r <= 1'b1;
    end else if (state_r != SSP_IDLE && !last_end_w) begin
      busy_r <= 1'b1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  // Done flag: set wins over every clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else if (finish_w) begin
      done_r <= 1'b1;
    end else if (rx_rd_w || tx_wr_w || st_rd_w || !any_en_w) begin
      done_r <= 1'b0;
    end
  end

  // Collision flag on access while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coll_r <= 1'b0;
    end else if ((rx_rd_w || tx_wr_w) && busy_r) begin
      coll_r <= 1'b1;
    end else if (!any_en_w) begin
      coll_r <= 1'b0;
    end
  end

  // Pin outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_clock          <= 1'b1;
      shared_data_line_out <= 1'b0;
      shared_data_line_oe  <= 1'b0;
      peripheral_enable_0  <= 1'b0;
      peripheral_enable_1  <= 1'b0;
    end else begin
      shift_clock <= ~((state_r == SSP_IDLE && (start_tx_w || start_rx_w))
                       || (state_r == SSP_LOW && !half_end_w)
                       || (state_r == SSP_HIGH && half_end_w &&
                           bit_r != `SSP_LAST_BIT));
      if (state_r == SSP_IDLE && start_tx_w) begin
        shared_data_line_out <= wr_data_w[0];
      end else if (state_r == SSP_HIGH && half_end_w && writing_r &&
                   bit_r != `SSP_LAST_BIT) begin
        shared_data_line_out <= shift_r[1];
      end
      // Driven only while writing; keeper outside holds level
      shared_data_line_oe <= (state_r == SSP_IDLE) ? start_tx_w
                           : (writing_r && !(state_r == SSP_HOLD &&
                                             half_end_w));
      peripheral_enable_0 <= ctrl_r[`SSP_CT_EN0];
      peripheral_enable_1 <= ctrl_r[`SSP_CT_EN1] &
                             ~ctrl_r[`SSP_CT_EN0];
    end
  end

endmodule

//--- verif/ssp_properties.sv
/* Port checker for ssp_master, bound at the foot of this file.
   Assumes one clock aclk and synchronous active-low aresetn. */
`timescale 1ns/100ps
module ssp_master_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        shift_clock,
  input wire logic        shared_data_line_out,
  input wire logic        shared_data_line_oe,
  input wire logic        peripheral_enable_0,
  input wire logic        peripheral_enable_1
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Shift clock low phases, and high phases while driving, last at most eight processor clocks
  sequence s_fall;
    $fell(shift_clock);
  endsequence
  sequence s_rise_drv;
    $rose(shift_clock) && shared_data_line_oe;
  endsequence
  property p_low_w;
    s_fall |-> ##[1:8] shift_clock;
  endproperty
  a_low_w: assert property (p_low_w)
    else $error("shift clock low phase too long");
  property p_high_w;
    s_rise_drv |-> ##[1:8] (!shift_clock || !shared_data_line_oe);
  endproperty
  a_high_w: assert property (p_high_w)
    else $error("write phase does not end");
  // Data moves only while the shift clock is low
  property p_drv_fall;
    $changed(shared_data_line_out) && shared_data_line_oe |-> !shift_clock;
  endproperty
  a_drv_fall: assert property (p_drv_fall)
    else $error("data changed with clock high");
  property p_start_low;
    $rose(shared_data_line_oe) |-> !shift_clock;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("drive began with clock high");
  property p_end_hold;
    $fell(shared_data_line_oe) |-> shift_clock && $past(shift_clock);
  endproperty
  a_end_hold: assert property (p_end_hold)
    else $error("last bit not held");
  // Enable outputs are exclusive
  property p_en_excl;
    !(peripheral_enable_0 && peripheral_enable_1);
  endproperty
  a_en_excl: assert property (p_en_excl)
    else $error("both enables high");
  // Read answers follow the address handshake
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_rd_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("read upper half not zero");
endmodule

bind ssp_master ssp_master_checker i_chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .shift_clock, .shared_data_line_out, .shared_data_line_oe,
  .peripheral_enable_0, .peripheral_enable_1
);

//--- verif/ssp_slave_model.sv
/* Slave peripheral on the shared data line, with the line keeper.
   Assumes the master's registered pins, sampled on aclk. */
`timescale 1ns/100ps
module ssp_slave_model (
  input  wire logic       aclk,
  input  wire logic       shift_clock,
  input  wire logic       en_any,
  input  wire logic       dev_oe,
  input  wire logic       dev_out,
  input  wire logic [7:0] send_byte,
  output logic            line,
  output logic [7:0]      got_byte
);
  logic       sck_q = 1'h1;
  logic       drv   = 1'h0;
  logic       val   = 1'h1;
  logic       keep  = 1'h1;
  logic [2:0] idx   = 3'h0;
  initial got_byte = 8'h00;
  // Line level: driver, else the keeper's last level
  always_comb line = dev_oe ? dev_out : (drv ? val : keep);
  // Edges seen one processor clock late
  always @(posedge aclk) begin
    sck_q <= shift_clock;
    keep <= line;
    if (sck_q && !shift_clock && !dev_oe && en_any) begin
      drv <= 1'h1;
      val <= send_byte[idx];
      idx <= idx + 3'h1;
    end
    if (!sck_q && shift_clock) begin
      if (dev_oe) got_byte <= {line, got_byte[7:1]};
      if (idx == 3'h0) drv <= 1'h0;
    end
  end
endmodule

//--- verif/tb_sync_serial_master_port.sv
/* Self-checking bench for ssp_master with a slave model.
   Assumes a 100 MHz aclk and the register header map. */
`timescale 1ns/100ps
`include "ssp_regs.svh"
module tb_sync_serial_master_port;
  import ssp_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, shift_clock;
  logic        shared_data_line_out, shared_data_line_oe, line, sck_q;
  logic        peripheral_enable_0, peripheral_enable_1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, send_byte, got_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] rdat;
  ssp_resp_t   s_axi_bresp, s_axi_rresp, resp;
  int          fail_count, total_checks, lo_n, lo_w, hi_n, hold_w, rises;

  ssp_master i_ssp_master (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .shift_clock,
    .shared_data_line_in(line), .shared_data_line_out,
    .shared_data_line_oe, .peripheral_enable_0, .peripheral_enable_1);
  ssp_slave_model i_ssp_slave_model (.aclk, .shift_clock,
    .en_any(peripheral_enable_0 | peripheral_enable_1),
    .dev_oe(shared_data_line_oe), .dev_out(shared_data_line_out),
    .send_byte, .line, .got_byte);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // Measure low phases, write hold and rising edges at the pins
  always @(posedge aclk) begin
    sck_q <= shift_clock;
    lo_n <= shift_clock ? 0 : lo_n + 1;
    if (shift_clock && lo_n != 0) lo_w <= lo_n;
    hi_n <= (shift_clock && shared_data_line_oe) ? hi_n + 1 : 0;
    if (!shared_data_line_oe && hi_n != 0) hold_w <= hi_n;
    if (shift_clock && !sck_q) rises <= rises + 1;
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 400) begin
      fail_count++;
      $display("[FAIL] wait expected answer seen timeout");
      give_verdict();
    end
  endtask
  // Bus write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 400);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 400);
    rdat = s_axi_rdata[15:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tmo(n);
  endtask
  // Wait for eight rising edges and a released, high line pair
  task automatic wait_end();
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(rises == 8 && shift_clock === 1'h1
                 && shared_data_line_oe === 1'h0) && n < 400);
    @(posedge aclk); // Pin measures settle one edge later
    tmo(n);
  endtask

  task automatic t_reset();
    chk("idle clock", shift_clock, 1'h1);
    rd(`SSP_ADDR_STATUS);
    chk("status reset", rdat, 16'h0000);
    wr(`SSP_ADDR_STATUS, 16'hffff);
    chk("ro write resp", resp, `SSP_RESP_OKAY);
    rd(`SSP_ADDR_STATUS);
    chk("status ro", rdat, 16'h0000);
    chk("status resp", resp, `SSP_RESP_OKAY);
    rd(8'h1c);
    chk("unmapped", resp, `SSP_RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_enables();
    for (int v = 0; v < 4; v++) begin
      wr(`SSP_ADDR_CONTROL, 16'(v));
      @(posedge aclk);
      chk("enable 0", peripheral_enable_0, v[0]);
      chk("enable 1", peripheral_enable_1, v[1] & ~v[0]);
    end
    $display("test enables done");
  endtask
  // One byte per divide code, alternating the two transmit registers
  task automatic t_transmit();
    logic [7:0] b;
    for (int c = 0; c < 4; c++) begin
      b = 8'h96 ^ 8'(c * 37);
      wr(`SSP_ADDR_CONTROL, 16'(c << 4) | 16'h0001);
      rises = 0;
      wr(c[0] ? `SSP_ADDR_TX1 : `SSP_ADDR_TX0, {8'h00, b});
      wait_end();
      chk("tx byte", got_byte, b);
      chk("low width", lo_w, 1 << c);
      chk("hold width", hold_w, 1 << c);
      rd(`SSP_ADDR_STATUS);
      chk("done set", rdat, 16'h0002);
      rd(`SSP_ADDR_STATUS);
      chk("done read clr", rdat, 16'h0000);
    end
    $display("test transmit done");
  endtask
  task automatic t_receive();
    send_byte = 8'ha5;
    wr(`SSP_ADDR_CONTROL, 16'h0032);
    rises = 0;
    rd(`SSP_ADDR_RECEIVE);
    chk("rx no drive", shared_data_line_oe, 1'h0);
    wait_end();
    wr(`SSP_ADDR_CONTROL, 16'h0030);
    rd(`SSP_ADDR_STATUS);
    chk("done en off", rdat, 16'h0000);
    rises = 0;
    rd(`SSP_ADDR_RECEIVE);
    chk("rx byte", rdat, 16'h00a5);
    repeat (20) @(posedge aclk);
    chk("rx no start", rises, 0);
    $display("test receive done");
  endtask
  // Accesses while busy flag a collision and start nothing
  task automatic t_collide();
    wr(`SSP_ADDR_CONTROL, 16'h0031);
    rises = 0;
    wr(`SSP_ADDR_TX0, 16'h003c);
    wr(`SSP_ADDR_TX1, 16'h00ff);
    rd(`SSP_ADDR_RECEIVE);
    rd(`SSP_ADDR_STATUS);
    chk("busy coll", rdat, 16'h0005);
    wait_end();
    chk("first byte", got_byte, 8'h3c);
    rd(`SSP_ADDR_STATUS);
    chk("done coll", rdat, 16'h0006);
    wr(`SSP_ADDR_CONTROL, 16'h0030);
    rd(`SSP_ADDR_STATUS);
    chk("coll clr", rdat, 16'h0000);
    chk("one byte", rises, 8);
    rd(`SSP_ADDR_TX1);
    chk("tx1 kept", rdat, 16'h00f9);
    rd(`SSP_ADDR_TX0);
    chk("tx0 stored", rdat, 16'h003c);
    $display("test collision done");
  endtask

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, sck_q} = 3'h1;
    {s_axi_awaddr, s_axi_araddr, send_byte} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    {fail_count, total_checks, rises} = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_enables();
    t_transmit();
    t_receive();
    t_collide();
    give_verdict();
  end
endmodule
